// File: dcfu_checker.sv
/* Channel 0 checker for dual_channel_fifo_uart.
   Assumes one clock, synchronous reset and a stable divisor. */
module dcfu_checker (
  input wire logic             clk,
  input wire logic             rst,
  input wire logic [1:0]       serial_tx_out,
  input wire logic [1:0]       rts_n_out,
  input wire logic [1:0][15:0] channel_control_reg,
  input wire logic [1:0][1:0]  modem_control_reg,
  input wire logic [1:0][15:0] bit_rate_divisor,
  input wire logic [1:0]       tx_wr_ready,
  input wire logic [1:0][2:0]  tx_rx_status_reg,
  input wire logic [1:0][9:0]  fifo_status_reg,
  input wire logic [1:0]       modem_status_reg,
  input wire logic [1:0]       rx_irq,
  input wire logic [1:0]       err_irq,
  input wire logic [1:0]       rx_dma_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [20:0] low_cnt;
  logic [20:0] bit_len;
  assign bit_len = {1'b0, bit_rate_divisor[0], 4'h0} + 21'h10;
  // A data frame is low for ten bits at most
  always_ff @(posedge clk) begin
    low_cnt <= (rst || serial_tx_out[0]) ? 21'h0 : low_cnt + 21'h1;
  end
  a_rx_ready_count: assert property (tx_rx_status_reg[0][0] == (fifo_status_reg[0][4:0] != 5'h0))
    else $error("rx ready vs count");
  a_tx_ready_full: assert property (channel_control_reg[0][4] |-> tx_wr_ready[0] == (fifo_status_reg[0][9:5] != 5'h10))
    else $error("tx ready vs count");
  a_tx_idle_high: assert property (tx_rx_status_reg[0][2] && !channel_control_reg[0][2] |-> serial_tx_out[0])
    else $error("idle tx line low");
  a_break_long: assert property ($rose(serial_tx_out[0]) && low_cnt > 10*bit_len+2 |-> low_cnt > 12*bit_len)
    else $error("break too short");
  a_err_irq_gate: assert property (!channel_control_reg[0][3] && !$past(channel_control_reg[0][3]) |-> !err_irq[0])
    else $error("err irq while off");
  a_rx_dma_route: assert property (channel_control_reg[0][0] && $past(channel_control_reg[0][0]) |-> !rx_irq[0])
    else $error("rx irq in dma");
  a_rx_irq_route: assert property (!channel_control_reg[0][0] && !$past(channel_control_reg[0][0]) |-> !rx_dma_req[0])
    else $error("rx dma in irq mode");
  a_cts_stall: assert property (modem_control_reg[0][1] && !modem_status_reg[0] && !$past(modem_status_reg[0]) |=> fifo_status_reg[0][9:5] >= $past(fifo_status_reg[0][9:5]))
    else $error("tx drained without cts");
  a_rts_full_off: assert property (modem_control_reg[0][1] && fifo_status_reg[0][4:0] == 5'h10 |-> ##[0:1] rts_n_out[0])
    else $error("rts on when full");
  a_rts_room_on: assert property (modem_control_reg[0][1] && $past(modem_control_reg[0][1]) && fifo_status_reg[0][4:0] < 5'he |-> ##[0:1] !rts_n_out[0])
    else $error("rts off with room");
endmodule : dcfu_checker

bind dual_channel_fifo_uart dcfu_checker i_dcfu_checker (.clk, .rst, .serial_tx_out, .rts_n_out,
  .channel_control_reg, .modem_control_reg, .bit_rate_divisor, .tx_wr_ready, .tx_rx_status_reg,
  .fifo_status_reg, .modem_status_reg, .rx_irq, .err_irq, .rx_dma_req);

// File: dual_channel_fifo_uart.sv
/*
  Two-channel asynchronous serial unit with FIFOs, flow control, break and
  receive error reporting. Assumes control bits are held stable by software,
  serial and handshake pins are asynchronous, and one 125 MHz clock.
*/
`include "uart_regs.svh"
module dual_channel_fifo_uart import uart_pkg::*; (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [1:0]       serial_rx_in,
  output logic      [1:0]       serial_tx_out,
  input  wire logic [1:0]       cts_n_in,
  output logic      [1:0]       rts_n_out,
  input  wire logic [1:0][5:0]  line_format_reg,
  input  wire logic [1:0][15:0] channel_control_reg,
  input  wire logic [1:0][1:0]  modem_control_reg,
  input  wire logic [1:0][15:0] bit_rate_divisor,
  input  wire logic [1:0]       tx_wr_valid,
  input  wire logic [1:0][7:0]  tx_wr_data,
  output logic      [1:0]       tx_wr_ready,
  input  wire logic [1:0]       rx_rd_strobe,
  output logic      [1:0][7:0]  rx_holding_reg,
  input  wire logic [1:0]       rx_err_rd_strobe,
  output logic      [1:0][3:0]  rx_error_status_reg,
  output logic      [1:0][2:0]  tx_rx_status_reg,
  output logic      [1:0][9:0]  fifo_status_reg,
  output logic      [1:0]       modem_status_reg,
  output logic      [1:0]       rx_irq,
  output logic      [1:0]       tx_irq,
  output logic      [1:0]       err_irq,
  output logic      [1:0]       rx_dma_req,
  output logic      [1:0]       tx_dma_req
);
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic [1:0]  rx_sync;
    logic [1:0]  cts_sync;
    logic        rx_bit;
    logic        cts_active;
    logic [5:0]  lf;
    logic [15:0] cc;
    logic [3:0]  nbits;
    logic        par_en;
    logic [1:0]  par_sel;
    logic        two_stop;
    logic        fifo_en;
    logic        afc;
    logic        send_break;
    logic [4:0]  limit;
    logic [3:0]  frame_bits;
    logic [15:0] div_cnt;
    logic        tick;
    // Transmit side
    tx_state_t   tx_state;
    logic [3:0]  tx_sub;
    logic [3:0]  tx_bitn;
    logic [7:0]  tx_shift;
    logic        tx_par;
    logic        tx_bit_end;
    logic        tx_go;
    logic        tx_full;
    logic [4:0]  tx_cnt;
    logic [7:0]  tx_head;
    logic        tx_req;
    logic        tx_line;
    // Receive side
    rx_state_t   rx_state;
    logic [3:0]  rx_sub;
    logic [3:0]  rx_bitn;
    logic [7:0]  rx_shift;
    logic        rx_par;
    logic        rx_sample;
    logic        rx_done;
    logic [7:0]  rx_aligned;
    logic [3:0]  rx_err_new;
    logic        rx_full;
    logic [4:0]  rx_cnt;
    logic [11:0] rx_head;
    logic        rx_push;
    logic        rx_pop;
    logic        ovr_pending;
    logic        head_reported;
    logic        err_set;
    logic [3:0]  err_stat;
    logic [9:0]  to_cnt;
    logic [9:0]  to_limit;
    logic        timeout;
    logic        rx_req;
    logic [4:0]  rx_free;
    logic        rts_active;

    // Two flops on every pin before any logic
    always_ff @(posedge clk) begin
      if (rst) begin
        rx_sync  <= 2'h3;
        cts_sync <= 2'h3;
      end else if (ce) begin
        rx_sync  <= {rx_sync[0], serial_rx_in[ch]};
        cts_sync <= {cts_sync[0], cts_n_in[ch]};
      end
    end
    assign rx_bit     = rx_sync[1];
    assign cts_active = !cts_sync[1];

    assign lf         = line_format_reg[ch];
    assign cc         = channel_control_reg[ch];
    assign nbits      = 4'h5 + {2'h0, lf[`LF_WLEN_MSB:`LF_WLEN_LSB]};
    assign two_stop   = lf[`LF_TWO_STOP];
    assign par_en     = lf[`LF_PAR_EN];
    assign par_sel    = lf[`LF_PAR_SEL_MSB:`LF_PAR_SEL_LSB];
    assign fifo_en    = cc[`CC_FIFO_EN];
    assign send_break = cc[`CC_SEND_BREAK];
    assign afc        = modem_control_reg[ch][`MC_AUTO_FLOW];
    // Non-FIFO mode shrinks both queues to a single holding register
    assign limit      = fifo_en ? 5'(`FIFO_DEPTH) : 5'h01;
    assign frame_bits = 4'h2 + nbits + {3'h0, par_en} + {3'h0, two_stop};

    // One tick per divisor+1 clocks; sixteen ticks make one bit
    assign tick = (div_cnt == 16'h0000);
    always_ff @(posedge clk) begin
      if (rst) begin
        div_cnt <= `DIV_RESET;
      end else if (ce) begin
        div_cnt <= tick ? bit_rate_divisor[ch] : div_cnt - 16'h0001;
      end
    end

    uart_fifo #(.WIDTH(8)) u_tx_fifo (
      .clk       (clk),
      .rst       (rst),
      .ce        (ce),
      .limit     (limit),
      .push      (tx_wr_valid[ch]),
      .push_data (tx_wr_data[ch]),
      .pop       (tx_go),
      .head      (tx_head),
      .count     (tx_cnt),
      .full      (tx_full)
    );
    assign tx_wr_ready[ch] = !tx_full;

    // A break request is only seen in idle, so the word on the line completes
    assign tx_go = (tx_state == TX_IDLE) && (tx_cnt != 5'h00) && !send_break
                   && (!afc || cts_active);
    assign tx_bit_end = tick && (tx_sub == 4'(`OVERSAMPLE - 1));

    always_ff @(posedge clk) begin
      if (rst) begin
        tx_state <= TX_IDLE;
        tx_sub   <= 4'h0;
        tx_bitn  <= 4'h0;
        tx_shift <= 8'h00;
        tx_par   <= 1'b0;
      end else if (ce) begin
        if (tx_state != TX_IDLE && tick) begin
          tx_sub <= tx_sub + 4'h1;
        end
        case (tx_state)
          TX_IDLE: begin
            tx_sub  <= 4'h0;
            tx_bitn <= 4'h0;
            if (send_break) begin
              tx_state <= TX_BREAK;
            end else if (tx_go) begin
              tx_shift <= tx_head;
              tx_par   <= parity_bit(tx_head & (8'hff >> (4'h8 - nbits)), par_sel);
              tx_state <= TX_START;
            end
          end
          TX_START: begin
            if (tx_bit_end) begin
              tx_state <= TX_DATA;
            end
          end
          TX_DATA: begin
            if (tx_bit_end) begin
              tx_shift <= {1'b0, tx_shift[7:1]};
              tx_bitn  <= tx_bitn + 4'h1;
              if (tx_bitn == nbits - 4'h1) begin
                tx_bitn  <= 4'h0;
                tx_state <= par_en ? TX_PARITY : TX_STOP;
              end
            end
          end
          TX_PARITY: begin
            if (tx_bit_end) begin
              tx_state <= TX_STOP;
            end
          end
          TX_STOP: begin
            if (tx_bit_end) begin
              if (two_stop && tx_bitn == 4'h0) begin
                tx_bitn <= 4'h1;
              end else begin
                tx_state <= TX_IDLE;
              end
            end
          end
          TX_BREAK: begin
            // Low for more bit times than the longest frame, then a mark
            // stop bit before queued data resumes
            if (tx_bit_end) begin
              if (tx_bitn < 4'(`BREAK_MIN_BITS)) begin
                tx_bitn <= tx_bitn + 4'h1;
              end else if (!send_break) begin
                tx_bitn  <= 4'h0;
                tx_state <= TX_STOP;
              end
            end
          end
          default: tx_state <= TX_IDLE;
        endcase
      end
    end

    always_comb begin
      case (tx_state)
        TX_START:  tx_line = 1'b0;
        TX_DATA:   tx_line = tx_shift[0];
        TX_PARITY: tx_line = tx_par;
        TX_BREAK:  tx_line = 1'b0;
        default:   tx_line = 1'b1;
      endcase
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        serial_tx_out[ch] <= 1'b1;
      end else if (ce) begin
        serial_tx_out[ch] <= tx_line;
      end
    end

    // Receiver: realign mid start bit, then sample every 16 ticks
    assign rx_sample  = tick && (rx_sub == 4'(`OVERSAMPLE - 1));
    assign rx_done    = (rx_state == RX_STOP) && rx_sample;
    assign rx_aligned = rx_shift >> (4'h8 - nbits);
    always_comb begin
      rx_err_new               = 4'h0;
      rx_err_new[`ERR_FRAME]   = !rx_bit;
      rx_err_new[`ERR_PARITY]  = par_en && (rx_par != parity_bit(rx_aligned, par_sel));
      // All data, parity and stop low means the line sat low a whole frame
      rx_err_new[`ERR_BREAK]   = (rx_aligned == 8'h00) && !rx_bit && !(par_en && rx_par);
      rx_err_new[`ERR_OVERRUN] = rx_full || ovr_pending;
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        rx_state <= RX_IDLE;
        rx_sub   <= 4'h0;
        rx_bitn  <= 4'h0;
        rx_shift <= 8'h00;
        rx_par   <= 1'b0;
      end else if (ce) begin
        if (tick) begin
          rx_sub <= rx_sub + 4'h1;
        end
        case (rx_state)
          RX_IDLE: begin
            rx_sub  <= 4'h0;
            rx_bitn <= 4'h0;
            if (!rx_bit) begin
              rx_state <= RX_START;
            end
          end
          RX_START: begin
            if (tick && rx_sub == 4'(`SAMPLE_MID)) begin
              rx_sub   <= 4'h0;
              rx_state <= rx_bit ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_sample) begin
              rx_shift <= {rx_bit, rx_shift[7:1]};
              rx_bitn  <= rx_bitn + 4'h1;
              if (rx_bitn == nbits - 4'h1) begin
                rx_state <= par_en ? RX_PARITY : RX_STOP;
              end
            end
          end
          RX_PARITY: begin
            if (rx_sample) begin
              rx_par   <= rx_bit;
              rx_state <= RX_STOP;
            end
          end
          RX_STOP: begin
            if (rx_sample) begin
              rx_state <= RX_IDLE;
            end
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end

    // FIFO mode drops a character that finds the queue full and carries the
    // overrun on the next stored one; non-FIFO mode overwrites the holder
    assign rx_push = rx_done && (!rx_full || !fifo_en);
    assign rx_pop  = rx_rd_strobe[ch] || (rx_done && rx_full && !fifo_en);

    uart_fifo #(.WIDTH(12)) u_rx_fifo (
      .clk       (clk),
      .rst       (rst),
      .ce        (ce),
      .limit     (limit),
      .push      (rx_push),
      .push_data ({rx_err_new, rx_aligned}),
      .pop       (rx_pop),
      .head      (rx_head),
      .count     (rx_cnt),
      .full      (rx_full)
    );
    assign rx_holding_reg[ch] = rx_head[7:0];

    always_ff @(posedge clk) begin
      if (rst) begin
        ovr_pending <= 1'b0;
      end else if (ce) begin
        if (rx_done && rx_full && fifo_en) begin
          ovr_pending <= 1'b1;
        end else if (rx_push) begin
          ovr_pending <= 1'b0;
        end
      end
    end

    // Errors report once, when their character sits at the head; in
    // non-FIFO mode the head is the new character, so that is immediate
    assign err_set = (rx_cnt != 5'h00) && (rx_head[11:8] != 4'h0) && !head_reported;
    always_ff @(posedge clk) begin
      if (rst) begin
        head_reported <= 1'b0;
        err_stat      <= 4'h0;
      end else if (ce) begin
        if (rx_pop && rx_cnt != 5'h00) begin
          head_reported <= 1'b0;
        end else if (err_set) begin
          head_reported <= 1'b1;
        end
        // A new error wins over a read in the same cycle
        err_stat <= (rx_err_rd_strobe[ch] ? 4'h0 : err_stat)
                    | (err_set ? rx_head[11:8] : 4'h0);
      end
    end
    assign rx_error_status_reg[ch] = err_stat;
    assign err_irq[ch] = cc[`CC_ERR_IRQ_EN] && (err_stat != 4'h0);

    // Time-out counts ticks while data waits and the line is idle
    assign to_limit = {6'h00, frame_bits} * 10'(`RX_TIMEOUT_CHARS * `OVERSAMPLE);
    assign timeout  = fifo_en && (rx_cnt != 5'h00) && (to_cnt >= to_limit);
    always_ff @(posedge clk) begin
      if (rst) begin
        to_cnt <= 10'h000;
      end else if (ce) begin
        if (!fifo_en || rx_cnt == 5'h00 || rx_state != RX_IDLE || rx_pop) begin
          to_cnt <= 10'h000;
        end else if (tick && !timeout) begin
          to_cnt <= to_cnt + 10'h001;
        end
      end
    end

    assign rx_req = fifo_en
        ? ((rx_cnt != 5'h00 && rx_cnt >= {1'b0, cc[`CC_RX_TRIG_MSB:`CC_RX_TRIG_LSB]}) || timeout)
        : (rx_cnt != 5'h00);
    assign tx_req = fifo_en
        ? (tx_cnt <= {1'b0, cc[`CC_TX_TRIG_MSB:`CC_TX_TRIG_LSB]})
        : (tx_cnt == 5'h00);
    assign rx_irq[ch]     = rx_req && !cc[`CC_RX_DMA];
    assign rx_dma_req[ch] = rx_req && cc[`CC_RX_DMA];
    assign tx_irq[ch]     = tx_req && !cc[`CC_TX_DMA];
    assign tx_dma_req[ch] = tx_req && cc[`CC_TX_DMA];

    // Hysteresis between thresholds keeps the handshake stable
    assign rx_free = 5'(`FIFO_DEPTH) - rx_cnt;
    always_ff @(posedge clk) begin
      if (rst) begin
        rts_active <= 1'b0;
      end else if (ce) begin
        if (!afc) begin
          rts_active <= modem_control_reg[ch][`MC_MANUAL_RTS];
        end else if (rx_free > 5'(`RTS_ON_FREE)) begin
          rts_active <= 1'b1;
        end else if (rx_free < 5'(`RTS_OFF_FREE)) begin
          rts_active <= 1'b0;
        end
      end
    end
    assign rts_n_out[ch] = !rts_active;

    assign tx_rx_status_reg[ch] = {tx_state == TX_IDLE, tx_cnt == 5'h00,
                                   rx_cnt != 5'h00};
    assign fifo_status_reg[ch]  = {tx_cnt, rx_cnt};
    assign modem_status_reg[ch] = cts_active;
  end
endmodule : dual_channel_fifo_uart

// File: tb_dual_channel_fifo_uart.sv
/* Bench for dual_channel_fifo_uart, one peer per channel.
   Assumes divisor 0: a bit is 16 clocks. */
module tb_dual_channel_fifo_uart;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk;
  logic                 rst;
  logic                 ce;
  wire logic [1:0]      rx_line;
  wire logic [1:0]      tx_line;
  wire logic [1:0]      cts_n;
  wire logic [1:0]      rts_n;
  logic [1:0][5:0]      lf;
  logic [1:0][15:0]     cc;
  logic [1:0][1:0]      mc;
  logic [1:0]           wr_valid;
  logic [1:0][7:0]      wr_data;
  wire logic [1:0]      wr_ready;
  logic [1:0]           rd;
  logic [1:0]           err_rd;
  wire logic [1:0][7:0] hold;
  wire logic [1:0][3:0] err_st;
  wire logic [1:0][2:0] trs;
  wire logic [1:0][9:0] fst;
  wire logic [1:0]      mst, rx_irq, tx_irq, err_irq, rx_dma, tx_dma;
  int                   error_cnt;
  int                   checks;
  int                   t;
  logic [7:0]           d;
  logic [7:0]           m;
  logic                 p;
  dual_channel_fifo_uart i_dual_channel_fifo_uart (.clk, .rst, .ce, .serial_rx_in(rx_line),
    .serial_tx_out(tx_line), .cts_n_in(cts_n), .rts_n_out(rts_n), .line_format_reg(lf),
    .channel_control_reg(cc), .modem_control_reg(mc), .bit_rate_divisor('0),
    .tx_wr_valid(wr_valid), .tx_wr_data(wr_data), .tx_wr_ready(wr_ready), .rx_rd_strobe(rd),
    .rx_holding_reg(hold), .rx_err_rd_strobe(err_rd), .rx_error_status_reg(err_st),
    .tx_rx_status_reg(trs), .fifo_status_reg(fst), .modem_status_reg(mst), .rx_irq, .tx_irq,
    .err_irq, .rx_dma_req(rx_dma), .tx_dma_req(tx_dma));
  uart_peer i_uart_peer_0 (.line_in(tx_line[0]), .clk, .line_out(rx_line[0]), .cts_n(cts_n[0]));
  uart_peer i_uart_peer_1 (.line_in(tx_line[1]), .clk, .line_out(rx_line[1]), .cts_n(cts_n[1]));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input string what, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict;
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task automatic wr(input logic [7:0] b);
    @(posedge clk);
    wr_valid[0] <= 1'b1;
    wr_data[0] <= b;
    do @(posedge clk); while (wr_ready[0] !== 1'b1);
    wr_valid[0] <= 1'b0;
  endtask : wr
  task automatic pop(input logic e);
    @(posedge clk);
    {rd[0], err_rd[0]} <= {1'b1, e};
    @(posedge clk);
    {rd[0], err_rd[0]} <= 2'b00;
    repeat (3) @(posedge clk);
  endtask : pop
  // Hung peer wait
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
  initial begin
    {rst, ce, lf, cc, mc, wr_valid, wr_data, rd, err_rd} = '0;
    rst = 1'b1;
    ce = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("tx idle", tx_line, 2'b11);
    check("status", trs[0], 3'b110);
    cc[0] <= 16'h0010;
    for (int k = 0; k < 4; k++) begin
      lf[0] <= {1'b1, k[1:0], k[0], k[1:0]};
      wr(8'hb5);
      i_uart_peer_0.recv(5 + k, d, p);
      m = 8'hb5 & ~(8'hff << (5 + k));
      check("tx data", d, m);
      check("tx parity", p, (k == 0) ? ~^m : (k == 1) ? ^m : (k == 2));
      repeat (48) @(posedge clk);
    end
    check("tx request", tx_irq[0], 1'b1);
    cc[0][1] <= 1'b1;
    repeat (3) @(posedge clk);
    check("tx dma", {tx_dma[0], tx_irq[0]}, 2'b10);
    lf <= {6'h00, 6'h2b};
    cc[0] <= 16'h0418;
    fork
      i_uart_peer_0.send(8'h41, 8, ^8'h41, 1'b1);
      i_uart_peer_1.send(8'h15, 5, -1, 1'b1);
    join
    i_uart_peer_0.send(8'h42, 8, ^8'h42, 1'b0);
    i_uart_peer_0.send(8'h43, 8, ^8'h43, 1'b1);
    check("below trigger", rx_irq[0], 1'b0);
    i_uart_peer_0.send(8'h44, 8, ~^8'h44, 1'b1);
    check("rx at trigger", rx_irq[0], 1'b1);
    check("rx head", {err_irq[0], err_st[0], hold[0]}, 13'h041);
    check("channel 1", hold[1], 8'h15);
    pop(1'b0);
    check("frame", {err_irq[0], err_st[0], hold[0]}, 13'h1242);
    pop(1'b1);
    check("err cleared", err_st[0], 4'h0);
    pop(1'b0);
    check("parity", {err_st[0], hold[0]}, 12'h444);
    check("no timeout", rx_irq[0], 1'b0);
    repeat (400) @(posedge clk);
    check("timeout early", rx_irq[0], 1'b0);
    repeat (200) @(posedge clk);
    check("timeout", rx_irq[0], 1'b1);
    pop(1'b1);
    cc[0] <= 16'h0008;
    i_uart_peer_0.send(8'h51, 8, ^8'h51, 1'b1);
    i_uart_peer_0.send(8'h52, 8, ^8'h52, 1'b1);
    check("overrun", {err_irq[0], err_st[0], hold[0]}, 13'h1852);
    pop(1'b1);
    i_uart_peer_0.brk();
    check("break", err_st[0][0], 1'b1);
    repeat (120) @(posedge clk);
    pop(1'b1);
    cc[0] <= 16'h0010;
    lf[0] <= 6'h03;
    wr(8'h81);
    fork
      i_uart_peer_0.recv(8, d, p);
      begin
        repeat (8) @(posedge clk);
        cc[0][2] <= 1'b1;
        wr(8'h42);
      end
    join
    check("pre-break word", d, 8'h81);
    t = 0;
    repeat (400) begin
      @(posedge clk);
      if (tx_line[0] === 1'b0) t++;
    end
    check("break long", t > 192, 1'b1);
    check("queued", fst[0][9:5], 5'h1);
    cc[0][2] <= 1'b0;
    i_uart_peer_0.recv(8, d, p);
    check("after break", d, 8'h42);
    mc[0] <= 2'b10;
    wr(8'h66);
    repeat (100) @(posedge clk);
    check("cts stall", fst[0][9:5], 5'h1);
    check("rts on", rts_n[0], 1'b0);
    i_uart_peer_0.cts_n <= 1'b0;
    i_uart_peer_0.recv(8, d, p);
    check("cts release", {mst[0], d}, 9'h166);
    for (int i = 0; i < 16; i++) i_uart_peer_0.send(i[7:0], 8, -1, 1'b1);
    check("rts full", {rts_n[0], rx_irq[0]}, 2'b11);
    cc[0][0] <= 1'b1;
    pop(1'b1);
    check("rx dma", {rx_dma[0], rx_irq[0], rts_n[0]}, 3'b101);
    pop(1'b0);
    pop(1'b0);
    check("rts room", {rts_n[0], hold[0]}, 9'h003);
    mc[0] <= 2'b01;
    repeat (3) @(posedge clk);
    check("manual rts", rts_n[0], 1'b0);
    mc[0] <= 2'b00;
    repeat (3) @(posedge clk);
    check("manual rts off", rts_n[0], 1'b1);
    print_verdict();
  end
endmodule : tb_dual_channel_fifo_uart

// File: uart_fifo.sv
/*
  Sixteen-entry synchronous FIFO with a run-time fill limit.
  Assumes push and pop come from logic on the same clock.
*/
`include "uart_regs.svh"
module uart_fifo import uart_pkg::*; #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [4:0]       limit,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  output logic [WIDTH-1:0]      head,
  output logic [4:0]            count,
  output logic                  full
);
  logic [WIDTH-1:0] mem [0:`FIFO_DEPTH-1];
  logic [3:0]       wr_ptr;
  logic [3:0]       rd_ptr;
  logic             do_push;
  logic             do_pop;

  // A push into a full FIFO is taken only together with a pop, which lets
  // the one-entry mode overwrite its unread character.
  assign full    = (count >= limit);
  assign do_pop  = pop && (count != 5'h00);
  assign do_push = push && (!full || do_pop);
  assign head    = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (ce && do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      count  <= 5'h00;
    end else if (ce) begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 4'h1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 4'h1;
      end
      if (do_push && !do_pop) begin
        count <= count + 5'h01;
      end else if (do_pop && !do_push) begin
        count <= count - 5'h01;
      end
    end
  end
endmodule : uart_fifo

// File: uart_peer.sv
/* Remote serial peer: sends and captures frames, drives clear-to-send.
   Assumes divisor 0: 16 clocks per bit. */
module uart_peer (
  input  wire logic line_in,
  input  wire logic clk,
  output logic      line_out,
  output logic      cts_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 16;
  initial {line_out, cts_n} = 2'b11;
  task automatic put(input logic b);
    @(posedge clk) line_out <= b;
    repeat (BIT - 1) @(posedge clk);
  endtask : put
  // Negative parity means none; one stop bit, the receiver checks one
  task automatic send(input logic [7:0] d, input int n, input int par, input logic stp);
    put(1'b0);
    for (int i = 0; i < n; i++) put(d[i]);
    if (par >= 0) put(par[0]);
    put(stp);
    put(1'b1);
    put(1'b1);
  endtask : send
  task automatic brk;
    for (int i = 0; i < 14; i++) put(1'b0);
    put(1'b1);
    put(1'b1);
  endtask : brk
  task automatic recv(input int n, output logic [7:0] d, output logic p);
    int t;
    d = 8'h00;
    t = 0;
    while (line_in !== 1'b1 && t++ < 5000) @(posedge clk);
    while (line_in !== 1'b0 && t++ < 5000) @(posedge clk);
    repeat (BIT / 2 + BIT) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      d[i] = line_in;
      repeat (BIT) @(posedge clk);
    end
    p = line_in;
  endtask : recv
endmodule : uart_peer

// File: uart_pkg.sv
/*
  Types and the parity helper shared by the UART files.
  Assumes nothing beyond the compiler.
*/
package uart_pkg;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP, TX_BREAK} tx_state_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;

  // Select codes: 00 odd, 01 even, 10 forced one, 11 forced zero
  function automatic logic parity_bit(input logic [7:0] data, input logic [1:0] sel);
    case (sel)
      2'h0:    parity_bit = ~^data;
      2'h1:    parity_bit = ^data;
      2'h2:    parity_bit = 1'b1;
      default: parity_bit = 1'b0;
    endcase
  endfunction : parity_bit
endpackage : uart_pkg

// File: uart_regs.svh
/*
  Field positions, reset values and timing counts for the dual channel UART.
  Assumes a single 125 MHz system clock; included by bare name.
*/
`ifndef UART_REGS_SVH
`define UART_REGS_SVH
// Overview of operation
// - Two independent channels, each moving data by interrupt or DMA request.
// - Each channel has 16-byte receive and transmit FIFOs beside its shifters.
// - Frame: start bit, 5 to 8 data bits, optional parity, 1 or 2 stops.
// - Break holds the serial output low longer than one whole frame.
// - Break starts after the current word ends; queued data resumes afterwards.
// - Overrun flagged when a new character meets an unread previous one; FIFO mode flags it only when the FIFO is full.
// - Parity error flagged when received parity mismatches the setting.
// - Frame error flagged when the stop bit is not high.
// - Break flagged when the receive line stays low a whole frame.
// - FIFO mode: data waiting and 3 idle character times raise time-out.
// - Auto flow: transmitter takes from FIFO only while clear-to-send active.
// - Auto flow: request-to-send on above 2 free bytes, off below 1.
// - Eight status conditions are reported per channel.
// - Receive errors request an interrupt only with error enable set.
// - Received character stored raises receive request, interrupt in interrupt mode.
// - Character moved to shifter raises transmit request, interrupt in interrupt mode.
// - In DMA mode those requests drive DMA request outputs instead.
// - FIFO mode uses trigger levels; non-FIFO mode uses buffer full/empty.
// - FIFO mode: a byte's error, overrun too, reports at the FIFO head.
// - Bit clock is master clock divided by 16 and by divisor plus one.
// - Two-bit word length selects 5 to 8 bits; one bit selects stops.
// - Error status FIFO follows data; reading data and status clears it.

`define FIFO_DEPTH       16
`define OVERSAMPLE       16
`define SAMPLE_MID       7
`define RTS_ON_FREE      2
`define RTS_OFF_FREE     1
`define RX_TIMEOUT_CHARS 3
`define BREAK_MIN_BITS   13

`define LF_WLEN_MSB      1
`define LF_WLEN_LSB      0
`define LF_TWO_STOP      2
`define LF_PAR_SEL_MSB   4
`define LF_PAR_SEL_LSB   3
`define LF_PAR_EN        5

`define CC_RX_DMA        0
`define CC_TX_DMA        1
`define CC_SEND_BREAK    2
`define CC_ERR_IRQ_EN    3
`define CC_FIFO_EN       4
`define CC_RX_TRIG_MSB   11
`define CC_RX_TRIG_LSB   8
`define CC_TX_TRIG_MSB   15
`define CC_TX_TRIG_LSB   12

`define MC_MANUAL_RTS    0
`define MC_AUTO_FLOW     1

`define ERR_OVERRUN      3
`define ERR_PARITY       2
`define ERR_FRAME        1
`define ERR_BREAK        0

`define DIV_RESET        16'h0000
`endif
